// ===== rtl/irf_pkg.sv
// Purpose: Constants for the infrared timer status flag block.
// Assumes: Single 50 MHz clock domain, asynchronous active-low reset.
// Notes: Register map is a small word-indexed plain port map.
package irf_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] IRF_ADDR_CTRL = 4'h0;
   localparam logic [3:0] IRF_ADDR_CARRIER = 4'h1;
   localparam logic [3:0] IRF_ADDR_STATUS = 4'h2;
   localparam logic [3:0] IRF_ADDR_MASK = 4'h3;
   localparam logic [3:0] IRF_ADDR_COUNT = 4'h4;
   localparam logic [3:0] IRF_ADDR_CAPTURE = 4'h5;
   localparam logic [3:0] IRF_ADDR_RELOAD = 4'h6;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int IRF_CTRL_EN = 0;
   localparam int IRF_CTRL_RX = 1;
   localparam int IRF_CTRL_BITCNT = 2;
   localparam int IRF_ST_WRAP = 0;
   localparam int IRF_ST_EVENT = 1;

   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic [15:0] IRF_CNT_MAX = 16'hffff;
   localparam logic [15:0] IRF_CNT_ZERO = 16'h0000;
   localparam logic [15:0] IRF_CARRIER_RST = 16'h0000;
   localparam logic [15:0] IRF_RELOAD_RST = 16'h0000;
   localparam logic [2:0] IRF_CTRL_RST = 3'h0;
   localparam logic [1:0] IRF_FLAGS_RST = 2'h0;
   localparam logic [16:0] IRF_IVL_ONE = 17'h00001;

   typedef enum logic [1:0] {IRF_IDLE, IRF_TX, IRF_RX} irf_mode_t;
endpackage : irf_pkg

// ===== rtl/irf_interval.sv
// Purpose: Interval timer expiring every twice the carrier period setting.
// Assumes: Restarted whenever not enabled.
// Notes: Setting of zero is treated as an interval of one cycle.
`timescale 1ns/1ps
`default_nettype none
module irf_interval
   import irf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Control
   input wire logic run,
   input wire logic [15:0] carrier_period_setting,
   // Event
   output logic expire
);
   logic [16:0] cnt_r;
   logic [16:0] cnt_nxt;
   logic [16:0] limit;
   logic hit;
   logic expire_r;

   // Twice the carrier setting, never below one cycle
   assign limit = (carrier_period_setting == IRF_CNT_ZERO) ? IRF_IVL_ONE :
                  {carrier_period_setting, 1'b0};
   assign hit = run && (cnt_r + IRF_IVL_ONE >= limit);
   assign cnt_nxt = (!run || hit) ? 17'h00000 : cnt_r + IRF_IVL_ONE;
   assign expire = expire_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 17'h00000;
         expire_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         expire_r <= hit;
      end
   end
endmodule : irf_interval
`default_nettype wire

// ===== rtl/irf_flag.sv
// Purpose: One sticky status flag, set by hardware, cleared by software.
// Assumes: Clear is a one-cycle write strobe with the written bit at zero.
// Notes: Set wins over a clear in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module irf_flag
   import irf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Control
   input wire logic set_evt,
   input wire logic clr_req,
   // State
   output logic flag
);
   logic flag_r;
   logic flag_nxt;

   // Set is idempotent: an already set flag just stays set
   assign flag_nxt = set_evt ? 1'b1 : (clr_req ? 1'b0 : flag_r);
   assign flag = flag_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end
endmodule : irf_flag
`default_nettype wire

// ===== rtl/irf_top.sv
// Purpose: Infrared timer counter with wrap and event status flags.
// Assumes: Capture input is a one-cycle synchronous pulse.
// Notes: Flags clear by writing zero to the status bit.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module irf_top
   import irf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Receive front end
   input wire logic capture_in,
   // Status and interrupt
   output logic counter_wrap_flag,
   output logic event_interrupt_flag,
   output logic irq
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [2:0] ctrl_r;
   logic [15:0] carrier_r;
   logic [15:0] reload_r;
   logic [1:0] mask_r;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic [15:0] capture_r;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic irq_r;
   logic wrap_q_r;
   logic event_q_r;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // One compare serves both strobes, so reads and writes decode alike
   function automatic logic idx_hit(input logic [3:0] a, input logic [3:0] t,
                                    input logic s);
      idx_hit = s && (a == t);
   endfunction : idx_hit

   wire wr_ctrl = idx_hit(reg_addr, IRF_ADDR_CTRL, reg_wr);
   wire wr_carrier = idx_hit(reg_addr, IRF_ADDR_CARRIER, reg_wr);
   wire wr_status = idx_hit(reg_addr, IRF_ADDR_STATUS, reg_wr);
   wire wr_mask = idx_hit(reg_addr, IRF_ADDR_MASK, reg_wr);
   wire wr_reload = idx_hit(reg_addr, IRF_ADDR_RELOAD, reg_wr);

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   // Idle holds the counter at zero and stops the interval timer
   wire enabled = ctrl_r[IRF_CTRL_EN];
   wire receive_mode = ctrl_r[IRF_CTRL_RX];
   wire receive_bit_count_mode = ctrl_r[IRF_CTRL_BITCNT];
   irf_mode_t mode;
   assign mode = !enabled ? IRF_IDLE : (receive_mode ? IRF_RX : IRF_TX);

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // Transmit counts down and reloads at zero; receive counts up and wraps
   // Going straight from receive to transmit counts down from the current
   // value; passing through idle first gives an immediate reload
   wire tx_reload = (mode == IRF_TX) && (count_r == IRF_CNT_ZERO);
   wire rx_wrap = (mode == IRF_RX) && (count_r == IRF_CNT_MAX);
   always_comb begin
      count_nxt = count_r;
      unique case (mode)
         IRF_IDLE: count_nxt = IRF_CNT_ZERO;
         IRF_TX: count_nxt = tx_reload ? reload_r : count_r - 16'h0001;
         IRF_RX: count_nxt = count_r + 16'h0001;
      endcase
   end

   // ----------------------------------------------------------------
   // Interval timer
   // ----------------------------------------------------------------
   // Runs only while counting received bits; restarts from zero otherwise
   logic ivl_expire;
   wire ivl_run = (mode == IRF_RX) && receive_bit_count_mode;
   irf_interval u_ivl (
      .clk(clk),
      .arst_n(arst_n),
      .run(ivl_run),
      .carrier_period_setting(carrier_r),
      .expire(ivl_expire)
   );

   // ----------------------------------------------------------------
   // Event sources
   // ----------------------------------------------------------------
   // Sources are exclusive by mode, so at most one is active per cycle
   wire cap_evt = (mode == IRF_RX) && !receive_bit_count_mode && capture_in;
   wire event_set = tx_reload
                    || cap_evt
                    || (ivl_run && ivl_expire);

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   logic wrap_flag;
   logic event_flag;
   // Clear is write-zero: software writes ones to the bits it keeps
   wire wrap_clr = wr_status && !reg_wdata[IRF_ST_WRAP];
   wire event_clr = wr_status && !reg_wdata[IRF_ST_EVENT];

   irf_flag u_wrap (
      .clk(clk),
      .arst_n(arst_n),
      .set_evt(rx_wrap),
      .clr_req(wrap_clr),
      .flag(wrap_flag)
   );
   irf_flag u_event (
      .clk(clk),
      .arst_n(arst_n),
      .set_evt(event_set),
      .clr_req(event_clr),
      .flag(event_flag)
   );

   wire [1:0] status = {event_flag, wrap_flag};
   // Level interrupt; the mask gates only this line, never the status
   wire irq_nxt = |(status & mask_r);

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // One-hot select; an idle cycle or an unmapped index reads as zero
   wire rd_ctrl = idx_hit(reg_addr, IRF_ADDR_CTRL, reg_rd);
   wire rd_carrier = idx_hit(reg_addr, IRF_ADDR_CARRIER, reg_rd);
   wire rd_status = idx_hit(reg_addr, IRF_ADDR_STATUS, reg_rd);
   wire rd_mask = idx_hit(reg_addr, IRF_ADDR_MASK, reg_rd);
   wire rd_count = idx_hit(reg_addr, IRF_ADDR_COUNT, reg_rd);
   wire rd_capture = idx_hit(reg_addr, IRF_ADDR_CAPTURE, reg_rd);
   wire rd_reload = idx_hit(reg_addr, IRF_ADDR_RELOAD, reg_rd);
   wire [15:0] ctrl_word = {13'h0000, ctrl_r};
   wire [15:0] status_word = {14'h0000, status};
   wire [15:0] mask_word = {14'h0000, mask_r};
   assign rdata_nxt = ({16{rd_ctrl}} & ctrl_word)
                      | ({16{rd_carrier}} & carrier_r)
                      | ({16{rd_status}} & status_word)
                      | ({16{rd_mask}} & mask_word)
                      | ({16{rd_count}} & count_r)
                      | ({16{rd_capture}} & capture_r)
                      | ({16{rd_reload}} & reload_r);

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Mode bits take effect in the cycle after the write
   logic [2:0] ctrl_nxt;
   assign ctrl_nxt = wr_ctrl ? reg_wdata[2:0] : ctrl_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= IRF_CTRL_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Carrier setting
   // ----------------------------------------------------------------
   // Read back as written; only the interval timer uses it
   logic [15:0] carrier_nxt;
   assign carrier_nxt = wr_carrier ? reg_wdata : carrier_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         carrier_r <= IRF_CARRIER_RST;
      end else begin
         carrier_r <= carrier_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Reload value
   // ----------------------------------------------------------------
   // Zero reloads on every cycle, so the event flag sets continuously
   logic [15:0] reload_nxt;
   assign reload_nxt = wr_reload ? reg_wdata : reload_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reload_r <= IRF_RELOAD_RST;
      end else begin
         reload_r <= reload_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt mask
   // ----------------------------------------------------------------
   // Same layout as the status word: bit 0 wrap, bit 1 event
   logic [1:0] mask_nxt;
   assign mask_nxt = wr_mask ? reg_wdata[1:0] : mask_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_r <= IRF_FLAGS_RST;
      end else begin
         mask_r <= mask_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Counter register
   // ----------------------------------------------------------------
   // Readable but not writable; software steers it only through the mode and the reload value
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_r <= IRF_CNT_ZERO;
      end else begin
         count_r <= count_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Capture register
   // ----------------------------------------------------------------
   // Holds the count seen in the cycle of the capture pulse
   logic [15:0] capture_nxt;
   assign capture_nxt = cap_evt ? count_r : capture_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         capture_r <= IRF_CNT_ZERO;
      end else begin
         capture_r <= capture_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Zero outside the answer cycle keeps the bus quiet when idle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt line
   // ----------------------------------------------------------------
   // One cycle behind the status bits, in step with the flag ports
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Wrap flag copy
   // ----------------------------------------------------------------
   // Registered copy so the port leaves straight from a flop
   logic wrap_q_nxt;
   assign wrap_q_nxt = wrap_flag;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wrap_q_r <= 1'b0;
      end else begin
         wrap_q_r <= wrap_q_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Event flag copy
   // ----------------------------------------------------------------
   logic event_q_nxt;
   assign event_q_nxt = event_flag;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         event_q_r <= 1'b0;
      end else begin
         event_q_r <= event_q_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Output ports
   // ----------------------------------------------------------------
   // Ports are plain copies of the flops above
   assign reg_rdata = rdata_r;
   assign irq = irq_r;
   assign counter_wrap_flag = wrap_q_r;
   assign event_interrupt_flag = event_q_r;
endmodule : irf_top
`default_nettype wire

// ===== testbench/irf_top_sva.sv
// Purpose: Port-level checks of the wrap and event status flags.
// Assumes: Flag ports and irq lag the internal status by one cycle.
// Notes: The mode is shadowed from writes seen on the register port.
`timescale 1ns/1ps
`default_nettype none
module irf_top_chk
   import irf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   // Front end and flags
   input wire logic capture_in,
   input wire logic counter_wrap_flag,
   input wire logic event_interrupt_flag,
   input wire logic irq
);
   logic [2:0] ctrl_r;
   wire logic st_wr = reg_wr && reg_addr == IRF_ADDR_STATUS;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) ctrl_r <= IRF_CTRL_RST;
      else if (reg_wr && reg_addr == IRF_ADDR_CTRL) ctrl_r <= reg_wdata[2:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   chk_wrap_rx_only: assert property (
      $rose(counter_wrap_flag) |-> $past(ctrl_r[IRF_CTRL_RX], 2))
      else $error("wrap flag rose outside receive mode");
   chk_wrap_sticky: assert property (
      $fell(counter_wrap_flag) |-> $past(st_wr && !reg_wdata[0], 2))
      else $error("wrap flag fell without a clearing write");
   chk_evt_sticky: assert property (
      $fell(event_interrupt_flag) |-> $past(st_wr && !reg_wdata[1], 2))
      else $error("event flag fell without a clearing write");
   chk_capture_sets: assert property (
      capture_in && ctrl_r == 3'h3 |-> ##2 event_interrupt_flag)
      else $error("capture did not set event flag");
   chk_capture_only: assert property (
      $rose(event_interrupt_flag) && $past(ctrl_r, 2) == 3'h3
      |-> $past(capture_in, 2))
      else $error("event flag rose without capture");
   chk_evt_hold: assert property (
      event_interrupt_flag && capture_in |-> ##1 event_interrupt_flag [*2])
      else $error("event flag dropped on repeated event");
   chk_irq_source: assert property (
      irq |-> counter_wrap_flag || event_interrupt_flag)
      else $error("irq high with no flag set");
   cover property ($rose(counter_wrap_flag));
   cover property ($rose(irq));
   cover property (capture_in && event_interrupt_flag);
endmodule : irf_top_chk
bind irf_top irf_top_chk u_chk (.clk(clk), .arst_n(arst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .capture_in(capture_in), .counter_wrap_flag(counter_wrap_flag),
   .event_interrupt_flag(event_interrupt_flag), .irq(irq));
`default_nettype wire

// ===== testbench/irf_rx_front.sv
// Purpose: Receive front end giving two capture pulses on request.
// Assumes: Pulses are one cycle, gap sets the idle cycles between.
// Notes: Gap of zero gives back-to-back pulses.
`timescale 1ns/1ps
`default_nettype none
module irf_rx_front (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Command
   input wire logic go,
   input wire logic [3:0] gap,
   // Pulse out
   output logic capture_in
);
   logic [3:0] wait_r;
   logic [1:0] left_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         left_r <= 2'h0;
         wait_r <= 4'h0;
         capture_in <= 1'b0;
      end else begin
         capture_in <= 1'b0;
         if (go) begin
            left_r <= 2'h2;
            wait_r <= gap;
         end else if (left_r != 2'h0) begin
            wait_r <= (wait_r == 4'h0) ? gap : wait_r - 4'h1;
            if (wait_r == 4'h0) begin
               capture_in <= 1'b1;
               left_r <= left_r - 2'h1;
            end
         end
      end
   end
endmodule : irf_rx_front
`default_nettype wire

// ===== testbench/tb_ir_timer_status_flags.sv
// Purpose: Register-level tests of the wrap and event flags.
// Assumes: Flag ports settle two cycles after their event.
// Notes: The wrap test runs a full 16-bit count.
`timescale 1ns/1ps
`default_nettype none
module tb_ir_timer_status_flags;
   import irf_pkg::*;
   logic clk, arst_n, reg_wr, reg_rd, go, capture_in;
   logic [3:0] reg_addr, gap;
   logic [15:0] reg_wdata, reg_rdata;
   logic counter_wrap_flag, event_interrupt_flag, irq;
   int bad_count, total_checks, cyc;
   irf_top dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .capture_in(capture_in),
      .counter_wrap_flag(counter_wrap_flag),
      .event_interrupt_flag(event_interrupt_flag), .irq(irq));
   irf_rx_front u_front (.clk(clk), .arst_n(arst_n), .go(go), .gap(gap),
      .capture_in(capture_in));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      check("rdata", reg_rdata, exp);
   endtask : rd
   // Bounded wait, then settle to mid-cycle
   task automatic wait_flag(input logic wrap, input int lim);
      int n = 0;
      while ((wrap ? counter_wrap_flag : event_interrupt_flag) !== 1'b1
         && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_flag
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      {arst_n, reg_wr, reg_rd, go} = 4'h0;
      {reg_addr, gap, reg_wdata} = 24'h0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      rd(IRF_ADDR_STATUS, 16'h0000);
      rd(4'hf, 16'h0000);
      $display("reset test done");
      wr(IRF_ADDR_MASK, 16'h0001);
      wr(IRF_ADDR_CTRL, 16'h0003);
      repeat (65000) @(negedge clk);
      check("wrap early", counter_wrap_flag, 16'h0);
      wait_flag(1'b1, 600);
      check("wrap", counter_wrap_flag, 16'h1);
      check("irq", irq, 16'h1);
      wr(IRF_ADDR_STATUS, 16'h0001);
      repeat (3) @(negedge clk);
      check("wrap kept", counter_wrap_flag, 16'h1);
      wr(IRF_ADDR_STATUS, 16'h0000);
      repeat (3) @(negedge clk);
      check("wrap clear", counter_wrap_flag, 16'h0);
      check("irq clear", irq, 16'h0);
      $display("wrap test done");
      @(posedge clk);
      go <= 1'b1;
      gap <= 4'h3;
      @(posedge clk);
      go <= 1'b0;
      repeat (16) @(negedge clk);
      rd(IRF_ADDR_STATUS, 16'h0002);
      check("irq masked", irq, 16'h0);
      wr(IRF_ADDR_STATUS, 16'h0000);
      repeat (3) @(negedge clk);
      check("event clear", event_interrupt_flag, 16'h0);
      $display("capture test done");
      wr(IRF_ADDR_MASK, 16'h0002);
      wr(IRF_ADDR_CARRIER, 16'h0004);
      wr(IRF_ADDR_CTRL, 16'h0007);
      repeat (9) @(negedge clk);
      check("interval early", event_interrupt_flag, 16'h0);
      wait_flag(1'b0, 3);
      check("interval", event_interrupt_flag, 16'h1);
      @(negedge clk);
      check("irq event", irq, 16'h1);
      rd(IRF_ADDR_CARRIER, 16'h0004);
      rd(IRF_ADDR_MASK, 16'h0002);
      rd(IRF_ADDR_CTRL, 16'h0007);
      $display("interval test done");
      wr(IRF_ADDR_RELOAD, 16'h0005);
      wr(IRF_ADDR_CTRL, 16'h0000);
      wr(IRF_ADDR_CTRL, 16'h0001);
      wr(IRF_ADDR_STATUS, 16'h0000);
      repeat (2) @(negedge clk);
      check("reload early", event_interrupt_flag, 16'h0);
      wait_flag(1'b0, 12);
      check("reload", event_interrupt_flag, 16'h1);
      rd(IRF_ADDR_COUNT, 16'h0003);
      rd(IRF_ADDR_RELOAD, 16'h0005);
      $display("transmit test done");
      wrap_up();
   end
endmodule : tb_ir_timer_status_flags
`default_nettype wire
